/* verilog/ioc_pkg.sv */
/*
  Constants, register map and helpers for the internal oscillator control block.
  Assumes a 200 MHz system clock on which the oscillators are modelled as enables.
*/
package ioc_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 5000;

  // Register offsets and reset values
  localparam logic [7:0] FAST_CTRL_ADDR = 8'hb2;
  localparam logic [7:0] SLOW_CTRL_ADDR = 8'he3;
  localparam logic [7:0] FAST_CTRL_RESET = 8'hc0;
  localparam logic [7:0] SLOW_CTRL_RESET = 8'h00;
  localparam logic [3:0] SLOW_TRIM_RESET = 4'h8;

  // Field positions; the trim field is used by the slow control register only
  localparam int ON_BIT = 7;
  localparam int SETTLED_BIT = 6;
  localparam int TRIM_MSB = 5;
  localparam int TRIM_LSB = 2;
  localparam int DIV_MSB = 1;
  localparam int DIV_LSB = 0;

  // Divider select codes
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;

  // Slow oscillator timing
  localparam int SLOW_OSC_KHZ = 80;
  localparam int SLOW_PERIOD_CYC = CLK_MHZ * 1000 / SLOW_OSC_KHZ;
  localparam int SLOW_HALF_CYC = SLOW_PERIOD_CYC / 2;
  localparam int TRIM_STEP_CYC = 8;
  localparam int TRIM_MID = 8;
  localparam int SLOW_HALF_MIN = SLOW_HALF_CYC - TRIM_MID * TRIM_STEP_CYC;

  // Settling times, least times rounded up to whole cycles
  localparam int FAST_SETTLE_NS = 1000;
  localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLOW_SETTLE_US = 10;
  localparam int SLOW_SETTLE_CYC =
    (SLOW_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Last count of the divider for a select code
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    case (sel)
      DIV_BY8: div_last = 3'h7;
      DIV_BY4: div_last = 3'h3;
      DIV_BY2: div_last = 3'h1;
      default: div_last = 3'h0;
    endcase
  endfunction

  // Half period in cycles; trim 0 is the shortest
  function automatic logic [10:0] trim_half(input logic [3:0] trim);
    trim_half = 11'(SLOW_HALF_MIN) + 11'(trim) * 11'(TRIM_STEP_CYC);
  endfunction
endpackage

/* verilog/ioc_clk_div.sv */
/*
  Divide-by-1/2/4/8 enable divider with a toggling level output.
  Assumes tick_in is synchronous to the system clock; each cycle it is high counts once.
*/
`timescale 1ns/1ps
module ioc_clk_div
  import ioc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [1:0] sel,
  output logic tick_out,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
    logic level;
  } ioc_div_s;

  ioc_div_s q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (clr) begin
      d.cnt = 3'h0;
      d.level = 1'b0;
    end else if (tick_in) begin
      if (q.cnt >= div_last(sel)) begin
        d.cnt = 3'h0;
        d.tick = 1'b1;
        d.level = ~q.level;
      end else begin
        d.cnt = q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
  assign level_out = q.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_div_from_input: assert property (tick_out |-> $past(tick_in) && !$past(clr))
    else $error("divider ticked without an input tick");
  chk_div_by_one: assert property (
    tick_in && !clr && sel == DIV_BY1 |=> tick_out && level_out != $past(level_out))
    else $error("divide by 1 missed a tick");
  chk_div_by_two: assert property (
    tick_in && !clr && sel == DIV_BY2 && q.cnt == 3'h0 ##1 tick_in && !clr && sel == DIV_BY2
    |=> tick_out)
    else $error("divide by 2 missed its second tick");
endmodule

/* verilog/ioc_slow_osc.sv */
/*
  Trimmable low-frequency oscillator model with a settling flag.
  Assumes trim may change at any time; it takes effect in the current half period.
*/
`timescale 1ns/1ps
module ioc_slow_osc
  import ioc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [3:0] trim,
  output logic edge_tick,
  output logic osc_level,
  output logic settled
);
  typedef struct packed {
    logic [10:0] cnt;
    logic level;
    logic tick;
    logic [11:0] settle_cnt;
    logic settled;
  } ioc_osc_s;

  ioc_osc_s q, d;

  initial begin
    if (SLOW_SETTLE_CYC > 4095 || SLOW_HALF_CYC + TRIM_MID * TRIM_STEP_CYC > 2047) begin
      $error("slow oscillator counts exceed counter widths");
    end
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!enable) begin
      d = '0;
    end else begin
      if (q.cnt + 11'h1 >= trim_half(trim)) begin
        d.cnt = 11'h0;
        d.level = ~q.level;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 11'h1;
      end
      if (!q.settled) begin
        if (q.settle_cnt == 12'(SLOW_SETTLE_CYC - 1)) begin
          d.settled = 1'b1;
        end else begin
          d.settle_cnt = q.settle_cnt + 12'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edge_tick = q.tick;
  assign osc_level = q.level;
  assign settled = q.settled;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_osc_half_len: assert property (
    enable && $stable(trim) && q.cnt == trim_half(trim) - 11'h1 |=> edge_tick)
    else $error("half period length does not follow trim");
  chk_osc_off_state: assert property (!enable |=> !settled && !osc_level)
    else $error("disabled oscillator still settled or running");
endmodule

/* verilog/ioc_osc_ctrl.sv */
/*
  Internal oscillator control: two control registers, core clock enable
  divider, slow oscillator with divider, and slow-edge timer capture.
  Assumes register and timer inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module ioc_osc_ctrl
  import ioc_pkg::*;
#(
  parameter logic [3:0] TRIM_RESET = SLOW_TRIM_RESET
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  output logic core_clock,
  output logic slow_osc_clk,
  input wire logic cap_mode_fall,
  input wire logic cap_mode_rise,
  input wire logic [15:0] fall_timer_count_pair,
  input wire logic [15:0] rise_timer_count_pair,
  output logic [15:0] fall_timer_reload_pair,
  output logic [15:0] rise_timer_reload_pair,
  output logic fall_capture,
  output logic rise_capture
);
  typedef struct packed {
    logic fast_osc_on;
    logic fast_osc_settled;
    logic [7:0] fast_settle_cnt;
    logic [1:0] fast_osc_divide_sel;
    logic slow_osc_on;
    logic [3:0] slow_osc_trim;
    logic [1:0] slow_osc_divide_sel;
    logic [7:0] rdata;
    logic core_en;
    logic slow_clk;
    logic slow_clk_prev;
    logic [15:0] fall_reload;
    logic [15:0] rise_reload;
    logic fall_cap;
    logic rise_cap;
  } ioc_ctrl_s;

  ioc_ctrl_s q, d;

  logic fast_tick;
  logic slow_edge;
  logic slow_level;
  logic slow_osc_settled;
  logic slow_div_level;

  initial begin
    if (FAST_SETTLE_CYC > 255 || FAST_SETTLE_CYC < 1) begin
      $error("fast settle count does not fit its counter");
    end
  end

  // Fast oscillator modelled as one enable per clk while running
  ioc_clk_div u_fast_div (
    .clk(clk),
    .resetn(resetn),
    .clr(!q.fast_osc_on),
    .tick_in(q.fast_osc_on),
    .sel(q.fast_osc_divide_sel),
    .tick_out(fast_tick),
    .level_out()
  );

  ioc_slow_osc u_slow_osc (
    .clk(clk),
    .resetn(resetn),
    .enable(q.slow_osc_on),
    .trim(q.slow_osc_trim),
    .edge_tick(slow_edge),
    .osc_level(slow_level),
    .settled(slow_osc_settled)
  );

  // Slow divider counts both oscillator edges, so level period is n periods
  ioc_clk_div u_slow_div (
    .clk(clk),
    .resetn(resetn),
    .clr(!q.slow_osc_on),
    .tick_in(slow_edge),
    .sel(q.slow_osc_divide_sel),
    .tick_out(),
    .level_out(slow_div_level)
  );

  always_comb begin
    d = q;
    d.fall_cap = 1'b0;
    d.rise_cap = 1'b0;

    // Register writes; read-only fields keep their state
    if (sfr_we) begin
      if (sfr_addr == FAST_CTRL_ADDR) begin
        d.fast_osc_on = sfr_wdata[ON_BIT];
        d.fast_osc_divide_sel = sfr_wdata[DIV_MSB:DIV_LSB];
      end else if (sfr_addr == SLOW_CTRL_ADDR) begin
        d.slow_osc_on = sfr_wdata[ON_BIT];
        d.slow_osc_trim = sfr_wdata[TRIM_MSB:TRIM_LSB];
        d.slow_osc_divide_sel = sfr_wdata[DIV_MSB:DIV_LSB];
      end
    end

    if (!q.fast_osc_on) begin
      d.fast_osc_settled = 1'b0;
      d.fast_settle_cnt = 8'h0;
    end else if (!q.fast_osc_settled) begin
      if (q.fast_settle_cnt == 8'(FAST_SETTLE_CYC - 1)) begin
        d.fast_osc_settled = 1'b1;
      end else begin
        d.fast_settle_cnt = q.fast_settle_cnt + 8'h1;
      end
    end

    // Register reads, answered one cycle later
    if (sfr_re) begin
      if (sfr_addr == FAST_CTRL_ADDR) begin
        d.rdata = {q.fast_osc_on, q.fast_osc_settled, 4'h0, q.fast_osc_divide_sel};
      end else if (sfr_addr == SLOW_CTRL_ADDR) begin
        d.rdata = {q.slow_osc_on, slow_osc_settled, q.slow_osc_trim, q.slow_osc_divide_sel};
      end else begin
        d.rdata = 8'h00;
      end
    end

    d.core_en = fast_tick;
    d.slow_clk = slow_div_level;
    // Edge detect on the registered slow clock
    d.slow_clk_prev = q.slow_clk;

    if (cap_mode_fall && q.slow_clk_prev && !q.slow_clk) begin
      d.fall_reload = fall_timer_count_pair;
      d.fall_cap = 1'b1;
    end
    if (cap_mode_rise && !q.slow_clk_prev && q.slow_clk) begin
      d.rise_reload = rise_timer_count_pair;
      d.rise_cap = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.fast_osc_on <= FAST_CTRL_RESET[ON_BIT];
      q.fast_osc_settled <= FAST_CTRL_RESET[SETTLED_BIT];
      q.fast_osc_divide_sel <= FAST_CTRL_RESET[DIV_MSB:DIV_LSB];
      q.slow_osc_on <= SLOW_CTRL_RESET[ON_BIT];
      q.slow_osc_trim <= TRIM_RESET;
      q.slow_osc_divide_sel <= SLOW_CTRL_RESET[DIV_MSB:DIV_LSB];
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata = q.rdata;
  assign core_clock = q.core_en;
  assign slow_osc_clk = q.slow_clk;
  assign fall_timer_reload_pair = q.fall_reload;
  assign rise_timer_reload_pair = q.rise_reload;
  assign fall_capture = q.fall_cap;
  assign rise_capture = q.rise_cap;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_fast_sel(logic [1:0] code);
    q.fast_osc_on && q.fast_osc_divide_sel == code;
  endsequence

  sequence s_fall_edge;
    cap_mode_fall && q.slow_clk_prev && !q.slow_clk;
  endsequence

  sequence s_rise_edge;
    cap_mode_rise && !q.slow_clk_prev && q.slow_clk;
  endsequence

  sequence s_slow_sel(logic [1:0] code);
    q.slow_osc_on && q.slow_osc_divide_sel == code;
  endsequence

  sequence s_fast_write;
    sfr_we && sfr_addr == FAST_CTRL_ADDR;
  endsequence

  sequence s_slow_write;
    sfr_we && sfr_addr == SLOW_CTRL_ADDR;
  endsequence

  sequence s_unmapped_read;
    sfr_re && sfr_addr != FAST_CTRL_ADDR && sfr_addr != SLOW_CTRL_ADDR;
  endsequence

  chk_fast_gate_off: assert property (!q.fast_osc_on |-> ##2 !core_clock)
    else $error("core clock ticks with fast oscillator off");
  chk_fast_ready_flag: assert property (
    !q.fast_osc_on |=> !q.fast_osc_settled ##0 (!q.fast_osc_on or !q.fast_osc_settled))
    else $error("fast ready flag set while stopped");
  chk_fast_div_one: assert property (s_fast_sel(DIV_BY1) [*3] |-> core_clock)
    else $error("undivided core clock missed a tick");
  chk_fast_div_two: assert property (
    s_fast_sel(DIV_BY2) [*4] ##0 core_clock |=> !core_clock ##1 core_clock)
    else $error("divide by 2 core clock spacing wrong");
  // Looks back so that a divide change after the pulse cannot matter
  chk_fast_div_four: assert property (
    s_fast_sel(DIV_BY4) [*6] ##0 core_clock
    |-> !$past(core_clock, 1) && !$past(core_clock, 2) && !$past(core_clock, 3))
    else $error("divide by 4 core clock spacing wrong");
  chk_fast_unused_zero: assert property (
    sfr_re && sfr_addr == FAST_CTRL_ADDR |=> sfr_rdata[TRIM_MSB:TRIM_LSB] == 4'h0)
    else $error("unused fast control bits read nonzero");
  chk_trim_write: assert property (
    sfr_we && sfr_addr == SLOW_CTRL_ADDR |=> q.slow_osc_trim == $past(sfr_wdata[5:2]))
    else $error("trim write not applied");
  chk_slow_gate_off: assert property (!q.slow_osc_on [*2] |-> ##1 !slow_osc_clk)
    else $error("slow clock runs while disabled");
  chk_fall_capture: assert property (
    s_fall_edge |=> fall_capture && fall_timer_reload_pair == $past(fall_timer_count_pair))
    else $error("falling edge capture missed");
  chk_rise_capture: assert property (
    s_rise_edge |=> rise_capture && rise_timer_reload_pair == $past(rise_timer_count_pair))
    else $error("rising edge capture missed");
  chk_capture_cause: assert property (
    fall_capture |-> $past(cap_mode_fall) && $fell(q.slow_clk_prev))
    else $error("capture without a falling edge");
  chk_fast_div_eight: assert property (
    s_fast_sel(DIV_BY8) [*8] ##0 core_clock
    |-> !$past(core_clock, 1) && !$past(core_clock, 2) && !$past(core_clock, 3))
    else $error("divide by 8 core clock spacing wrong");

  // Control writes land on the next edge
  chk_fast_write_fields: assert property (
    s_fast_write |=> q.fast_osc_on == $past(sfr_wdata[ON_BIT])
      && q.fast_osc_divide_sel == $past(sfr_wdata[DIV_MSB:DIV_LSB]))
    else $error("fast control write not applied");
  chk_slow_write_fields: assert property (
    s_slow_write |=> q.slow_osc_on == $past(sfr_wdata[ON_BIT])
      && q.slow_osc_divide_sel == $past(sfr_wdata[DIV_MSB:DIV_LSB]))
    else $error("slow control write not applied");
  chk_trim_hold: assert property (
    !(sfr_we && sfr_addr == SLOW_CTRL_ADDR) |=> $stable(q.slow_osc_trim))
    else $error("trim changed without a write");

  // Fast ready flag rises only after its settling time; slow only while enabled
  chk_fast_ready_time: assert property (
    $rose(q.fast_osc_settled) |-> $past(q.fast_osc_on)
      && $past(q.fast_settle_cnt) == 8'(FAST_SETTLE_CYC - 1))
    else $error("fast ready flag rose before settling");
  chk_slow_ready_time: assert property (
    $rose(slow_osc_settled) |-> $past(q.slow_osc_on))
    else $error("slow ready flag rose while disabled");

  // Slow oscillator and its divider
  chk_slow_osc_stop: assert property (!q.slow_osc_on |=> !slow_level)
    else $error("slow oscillator runs while disabled");
  chk_slow_div_one: assert property (
    s_slow_sel(DIV_BY1) ##0 slow_edge |=> ##1 slow_osc_clk != $past(slow_osc_clk))
    else $error("undivided slow clock missed an edge");

  // Read data changes only on a read; unmapped reads give zero
  chk_read_hold: assert property (!sfr_re |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_unmapped_read: assert property (s_unmapped_read |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned data");

  // Captures need their mode; reloads move only on a capture
  chk_fall_refused: assert property (!cap_mode_fall |=> !fall_capture)
    else $error("falling capture with its mode off");
  chk_rise_refused: assert property (!cap_mode_rise |=> !rise_capture)
    else $error("rising capture with its mode off");
  chk_fall_hold: assert property (!fall_capture |-> $stable(fall_timer_reload_pair))
    else $error("falling reload changed without a capture");
  chk_rise_hold: assert property (!rise_capture |-> $stable(rise_timer_reload_pair))
    else $error("rising reload changed without a capture");
endmodule

/* verification/ioc_osc_ctrl_tb_top.sv */
/*
  Self-checking bench for the internal oscillator control block.
  Assumes ioc_pkg and ioc_osc_ctrl are compiled first; bench drives on falling edges.
*/
`timescale 1ns/1ps
module ioc_osc_ctrl_tb_top import ioc_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_we = 1'b0;
  logic sfr_re = 1'b0;
  logic cap_mode_fall = 1'b0;
  logic cap_mode_rise = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] cnt_n;
  logic [7:0] sfr_rdata;
  logic core_clock;
  logic slow_osc_clk;
  logic [15:0] fall_reload;
  logic [15:0] rise_reload;
  logic fall_capture;
  logic rise_capture;
  int bad_count = 0;
  int tests_run = 0;

  assign cnt_n = ~cnt;

  ioc_osc_ctrl uut (
    .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
    .core_clock(core_clock), .slow_osc_clk(slow_osc_clk),
    .cap_mode_fall(cap_mode_fall), .cap_mode_rise(cap_mode_rise),
    .fall_timer_count_pair(cnt), .rise_timer_count_pair(cnt_n),
    .fall_timer_reload_pair(fall_reload), .rise_timer_reload_pair(rise_reload),
    .fall_capture(fall_capture), .rise_capture(rise_capture)
  );

  always #2.5 clk = ~clk;

  // Free-running timer count; the rising capture path sees its inverse
  always @(negedge clk) cnt <= cnt + 16'h0001;

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    $display("unexpected wait limit at %0t", $time);
    test_done();
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge clk);
    sfr_re = 1'b0;
    d = sfr_rdata;
  endtask

  // Cycles between two core clock pulses
  task automatic core_gap(output int n);
    int i;
    for (i = 0; i < 50 && core_clock !== 1'b1; i++) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (core_clock !== 1'b1 && n < 50);
    if (n >= 50) timeout();
  endtask

  task automatic slow_half(output int n);
    logic old;
    old = slow_osc_clk;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (slow_osc_clk === old && n < 40000);
    if (n >= 40000) timeout();
  endtask

  // Third level is clear of any divider or trim change
  task automatic measure_slow(output int n);
    slow_half(n);
    slow_half(n);
    slow_half(n);
  endtask

  // Capture takes the count that stands at the capturing edge
  task automatic cap_wait(input logic rise, output logic [15:0] r);
    logic [15:0] prev;
    int i;
    logic hit;
    hit = 1'b0;
    prev = cnt;
    for (i = 0; i < 3000 && !hit; i++) begin
      @(posedge clk);
      prev = cnt;
      #1;
      if ((rise ? fall_capture : rise_capture) !== 1'b0) begin
        chk8({7'h00, 1'b1}, 8'h00);
      end
      if ((rise ? rise_capture : fall_capture) === 1'b1) begin
        hit = 1'b1;
        r = rise ? rise_reload : fall_reload;
        chk16(r, rise ? ~prev : prev);
        chk8({7'h00, slow_osc_clk}, {7'h00, rise});
      end
    end
    if (!hit) timeout();
  endtask

  task automatic test_reset;
    logic [7:0] d;
    rd(FAST_CTRL_ADDR, d);
    chk8(d, FAST_CTRL_RESET);
    rd(SLOW_CTRL_ADDR, d);
    chk8(d, {2'b00, SLOW_TRIM_RESET, 2'b00});
    rd(8'h55, d);
    chk8(d, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_fast;
    logic [7:0] d;
    int n;
    int c;
    int i;
    int p;
    for (c = 0; c < 4; c++) begin
      wr(FAST_CTRL_ADDR, 8'h80 | 8'(c));
      measure_core: begin
        core_gap(n);
        core_gap(n);
        core_gap(n);
      end
      chkn(n, 8 >> c);
    end
    wr(FAST_CTRL_ADDR, 8'hbf);
    rd(FAST_CTRL_ADDR, d);
    chk8(d, 8'hc3);
    wr(FAST_CTRL_ADDR, 8'h03);
    repeat (3) @(negedge clk);
    p = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (core_clock !== 1'b0) p++;
    end
    chkn(p, 0);
    rd(FAST_CTRL_ADDR, d);
    chk8(d, 8'h03);
    wr(FAST_CTRL_ADDR, 8'h83);
    rd(FAST_CTRL_ADDR, d);
    chk8(d, 8'h83);
    repeat (FAST_SETTLE_CYC + 10) @(negedge clk);
    rd(FAST_CTRL_ADDR, d);
    chk8(d, 8'hc3);
    core_gap(n);
    core_gap(n);
    chkn(n, 1);
    $display("test fast done");
  endtask

  task automatic test_slow;
    logic [7:0] d;
    int n;
    int c;
    wr(SLOW_CTRL_ADDR, 8'he3);
    rd(SLOW_CTRL_ADDR, d);
    chk8(d, 8'ha3);
    repeat (SLOW_SETTLE_CYC + 10) @(negedge clk);
    rd(SLOW_CTRL_ADDR, d);
    chk8(d, 8'he3);
    measure_slow(n);
    chkn(n, SLOW_HALF_CYC);
    wr(SLOW_CTRL_ADDR, 8'h83);
    measure_slow(n);
    chkn(n, SLOW_HALF_MIN);
    rd(SLOW_CTRL_ADDR, d);
    chk8(d, 8'hc3);
    for (c = 0; c < 3; c++) begin
      wr(SLOW_CTRL_ADDR, 8'h80 | 8'(c));
      measure_slow(n);
      chkn(n, (8 >> c) * SLOW_HALF_MIN);
    end
    $display("test slow done");
  endtask

  task automatic test_capture;
    logic [7:0] d;
    logic [15:0] a;
    logic [15:0] b;
    int n;
    int i;
    int p;
    wr(SLOW_CTRL_ADDR, 8'h83);
    slow_half(n);
    slow_half(n);
    cap_mode_fall = 1'b1;
    cap_wait(1'b0, a);
    cap_wait(1'b0, b);
    chk16(b - a, 16'(2 * SLOW_HALF_MIN));
    @(negedge clk);
    cap_mode_fall = 1'b0;
    cap_mode_rise = 1'b1;
    cap_wait(1'b1, a);
    @(negedge clk);
    cap_mode_rise = 1'b0;
    p = 0;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((fall_capture | rise_capture) !== 1'b0) p++;
    end
    chkn(p, 0);
    if (slow_osc_clk !== 1'b1) slow_half(n);
    wr(SLOW_CTRL_ADDR, 8'h03);
    repeat (3) @(negedge clk);
    p = 0;
    for (i = 0; i < 10; i++) begin
      @(negedge clk);
      if (slow_osc_clk !== 1'b0) p++;
    end
    chkn(p, 0);
    rd(SLOW_CTRL_ADDR, d);
    chk8(d, 8'h03);
    $display("test capture done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    test_reset();
    test_fast();
    test_slow();
    test_capture();
    test_done();
  end
endmodule
